// [common/dsw_pkg.sv]
`default_nettype none
package dsw_pkg;
	localparam int DS_W = 8;
	localparam int PROG_AW = 12;
	localparam int BLK_W = 6;
	localparam int OFS_W = 6;
	localparam int RAM_AW = 6;
	localparam int STACK_DEPTH = 6;
	localparam int PC_W = 12;
	localparam int RD_LATENCY = 2;

	// Data-space offsets
	localparam logic [7:0] OFS_WIN_LO = 8'h40;
	localparam logic [7:0] OFS_WIN_HI = 8'h7f;
	localparam logic [7:0] OFS_X = 8'h80;
	localparam logic [7:0] OFS_Y = 8'h81;
	localparam logic [7:0] OFS_V = 8'h82;
	localparam logic [7:0] OFS_W_REG = 8'h83;
	localparam logic [7:0] OFS_RAM_LO = 8'h84;
	localparam logic [7:0] OFS_RAM_HI = 8'hbf;
	localparam logic [7:0] OFS_PA_DATA = 8'hc0;
	localparam logic [7:0] OFS_PB_DATA = 8'hc1;
	localparam logic [7:0] OFS_PA_DIR = 8'hc4;
	localparam logic [7:0] OFS_PB_DIR = 8'hc5;
	localparam logic [7:0] OFS_INT_OPT = 8'hc8;
	localparam logic [7:0] OFS_WIN_SEL = 8'hc9;
	localparam logic [7:0] OFS_PA_OPT = 8'hcc;
	localparam logic [7:0] OFS_PB_OPT = 8'hcd;
	localparam logic [7:0] OFS_CONV_RES = 8'hd0;
	localparam logic [7:0] OFS_CONV_CTL = 8'hd1;
	localparam logic [7:0] OFS_TPSC = 8'hd2;
	localparam logic [7:0] OFS_TCNT = 8'hd3;
	localparam logic [7:0] OFS_TSC = 8'hd4;
	localparam logic [7:0] OFS_WDG = 8'hd8;
	localparam logic [7:0] OFS_ACC = 8'hff;

	// Window select field
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 5;

	// Reset values
	localparam logic [7:0] RST_PORT = 8'h00;
	localparam logic [7:0] RST_CONV_CTL = 8'h40;
	localparam logic [7:0] RST_TPSC = 8'h7f;
	localparam logic [7:0] RST_TCNT = 8'hff;
	localparam logic [7:0] RST_TSC = 8'h00;
	localparam logic [7:0] RST_WDG = 8'hfe;

	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_ROM,
		SRC_RAM,
		SRC_REG
	} dsw_src_t;
endpackage : dsw_pkg
`default_nettype wire

// [common/dsw_mem_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface dsw_mem_if #(parameter int AW = 12, parameter int DW = 8);
	logic we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] a_addr;
	logic [DW-1:0] a_data;
	logic [AW-1:0] b_addr;
	logic [DW-1:0] b_data;
	modport ctrl (output we, waddr, wdata, a_addr, b_addr, input a_data, b_data);
	modport mem (input we, waddr, wdata, a_addr, b_addr, output a_data, b_data);
endinterface : dsw_mem_if
`default_nettype wire

// [logic/dsw_mem.sv]
`timescale 1ns/10ps
`default_nettype none
module dsw_mem #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	input wire logic i_core_clk, // Core clock
	input wire logic i_rst, // Async reset, clears read data only
	dsw_mem_if.mem bus // Write port and two read ports
);
	if (AW < 1 || AW > 16 || DW < 1) begin : g_bad_size
		$error("dsw_mem: unsupported size");
	end

	logic [DW-1:0] mem_q [2**AW];

	// Contents are not reset; they are loaded like a real array
	always_ff @(posedge i_core_clk) begin
		if (bus.we) begin
			mem_q[bus.waddr] <= bus.wdata;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			bus.a_data <= '0;
			bus.b_data <= '0;
		end else begin
			bus.a_data <= mem_q[bus.a_addr];
			bus.b_data <= mem_q[bus.b_addr];
		end
	end
endmodule : dsw_mem
`default_nettype wire

// [logic/dsw_data_space.sv]
// How it works
// R01 - Data addresses 40h to 7Fh decode as the program memory window.
// R02 - A window read returns one of 64 consecutive program bytes, anywhere below 1000h.
// R03 - The 4K program memory splits into 64 blocks of 64 bytes.
// R04 - Block zero covers 0000h to 003Fh; higher blocks follow upward.
// R05 - Writing the select register moves the window in 64-byte steps.
// R06 - The select register sits at C9h and takes plain data writes.
// R07 - Reset leaves the select register untouched and undefined.
// R08 - Software writes the select register before its first window read.
// R09 - Select bits 5:0 give the upper address; software writes 7:6 as zero.
// R10 - Software never reads or read-modify-writes the select register.
// R11 - Window data comes from the same memory that holds executable code.
// R12 - A six-level stack of 12-bit return addresses is kept.
// R13 - Port data reads give stored bits for outputs, live pins for inputs.
// R14 - Software keeps bits of absent pins at reset value.
// R15 - Software avoids bit set or clear on ports with input pins.
// R16 - Software loads the block number, then reads the window at the offset.
// R17 - Window program address is select bits joined with address bits 5:0.
`timescale 1ns/10ps
`default_nettype none
module dsw_data_space (
	input wire logic i_core_clk, // Core clock, 250 MHz
	input wire logic i_rst, // Async reset, active high
	input wire logic [dsw_pkg::DS_W-1:0] i_ds_addr, // Data-space address
	input wire logic i_ds_rd, // Read strobe
	input wire logic i_ds_wr, // Write strobe
	input wire logic [dsw_pkg::DS_W-1:0] i_ds_wdata, // Write data
	output logic [dsw_pkg::DS_W-1:0] o_ds_rdata, // Read data
	output logic o_ds_rvalid, // Read data valid pulse
	input wire logic [dsw_pkg::PROG_AW-1:0] i_fetch_addr, // Instruction fetch address
	output logic [dsw_pkg::DS_W-1:0] o_fetch_data, // Fetched byte
	input wire logic i_prog_we, // Program memory load strobe
	input wire logic [dsw_pkg::PROG_AW-1:0] i_prog_addr, // Load address
	input wire logic [dsw_pkg::DS_W-1:0] i_prog_wdata, // Load data
	input wire logic i_stk_push, // Push return address
	input wire logic i_stk_pop, // Pop return address
	input wire logic [dsw_pkg::PC_W-1:0] i_stk_pc, // Address to push
	output logic [dsw_pkg::PC_W-1:0] o_stk_top, // Stack top
	input wire logic [dsw_pkg::DS_W-1:0] i_pa_pin, // Port A pin levels
	output logic [dsw_pkg::DS_W-1:0] o_pa_out, // Port A drive value
	output logic [dsw_pkg::DS_W-1:0] o_pa_oe, // Port A drive enable
	input wire logic [dsw_pkg::DS_W-1:0] i_pb_pin, // Port B pin levels
	output logic [dsw_pkg::DS_W-1:0] o_pb_out, // Port B drive value
	output logic [dsw_pkg::DS_W-1:0] o_pb_oe, // Port B drive enable
	input wire logic [dsw_pkg::DS_W-1:0] i_conv_result // Converter result
);
	import dsw_pkg::*;

	function automatic dsw_src_t decode(input logic [7:0] addr);
		dsw_src_t src;
		src = SRC_NONE;
		if (addr >= OFS_WIN_LO && addr <= OFS_WIN_HI) begin
			src = SRC_ROM;
		end else if (addr >= OFS_RAM_LO && addr <= OFS_RAM_HI) begin
			src = SRC_RAM;
		end else if (addr >= OFS_X) begin
			src = SRC_REG;
		end
		return src;
	endfunction : decode

	function automatic logic [7:0] port_view(input logic [7:0] data,
		input logic [7:0] dir, input logic [7:0] pins);
		return (data & dir) | (pins & ~dir);
	endfunction : port_view

	dsw_mem_if #(.AW(PROG_AW), .DW(DS_W)) rom_bus ();
	dsw_mem_if #(.AW(RAM_AW), .DW(DS_W)) ram_bus ();

	dsw_src_t src_d;
	dsw_src_t src_q;
	logic rd_q;
	logic [BLK_W-1:0] win_sel_q;
	logic [7:0] x_q;
	logic [7:0] y_q;
	logic [7:0] v_q;
	logic [7:0] w_q;
	logic [7:0] acc_q;
	logic [7:0] int_opt_q;
	logic [7:0] pa_data_q;
	logic [7:0] pb_data_q;
	logic [7:0] pa_dir_q;
	logic [7:0] pb_dir_q;
	logic [7:0] pa_opt_q;
	logic [7:0] pb_opt_q;
	logic [7:0] conv_ctl_q;
	logic [7:0] tpsc_q;
	logic [7:0] tcnt_q;
	logic [7:0] tsc_q;
	logic [7:0] wdg_q;
	logic [7:0] pa_view;
	logic [7:0] pb_view;
	logic [7:0] reg_rdata_d;
	logic [7:0] reg_rdata_q;
	logic [1:0][7:0] pin_s1_q;
	logic [1:0][7:0] pin_s2_q;
	logic [1:0][7:0] pin_s3_q;
	logic [1:0][7:0] pin_lvl_q;
	logic [PC_W-1:0] stk_q [STACK_DEPTH];

	assign src_d = decode(i_ds_addr); // R01

	// One physical array serves both fetch and window reads
	assign rom_bus.we = i_prog_we;
	assign rom_bus.waddr = i_prog_addr;
	assign rom_bus.wdata = i_prog_wdata;
	assign rom_bus.a_addr = {win_sel_q, i_ds_addr[OFS_W-1:0]}; // R17 R04 R03
	assign rom_bus.b_addr = i_fetch_addr; // R11
	assign o_fetch_data = rom_bus.b_data;

	dsw_mem #(
		.AW(PROG_AW),
		.DW(DS_W)
	) u_prog_mem (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.bus(rom_bus)
	);

	// Data RAM; second read port serves nothing but keeps one memory type
	assign ram_bus.we = i_ds_wr && (src_d == SRC_RAM);
	assign ram_bus.waddr = i_ds_addr[RAM_AW-1:0];
	assign ram_bus.wdata = i_ds_wdata;
	assign ram_bus.a_addr = i_ds_addr[RAM_AW-1:0];
	assign ram_bus.b_addr = '0;

	dsw_mem #(
		.AW(RAM_AW),
		.DW(DS_W)
	) u_data_ram (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.bus(ram_bus)
	);

	// Undefined after reset: these have no reset on purpose
	always_ff @(posedge i_core_clk) begin
		if (i_ds_wr) begin
			case (i_ds_addr)
				OFS_WIN_SEL: win_sel_q <= i_ds_wdata[SEL_MSB:SEL_LSB]; // R05 R06 R07 R09
				OFS_X: x_q <= i_ds_wdata;
				OFS_Y: y_q <= i_ds_wdata;
				OFS_V: v_q <= i_ds_wdata;
				OFS_W_REG: w_q <= i_ds_wdata;
				OFS_ACC: acc_q <= i_ds_wdata;
				OFS_INT_OPT: int_opt_q <= i_ds_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pa_data_q <= RST_PORT;
			pb_data_q <= RST_PORT;
			pa_dir_q <= RST_PORT;
			pb_dir_q <= RST_PORT;
			pa_opt_q <= RST_PORT;
			pb_opt_q <= RST_PORT;
			conv_ctl_q <= RST_CONV_CTL;
			tpsc_q <= RST_TPSC;
			tcnt_q <= RST_TCNT;
			tsc_q <= RST_TSC;
			wdg_q <= RST_WDG;
		end else if (i_ds_wr) begin
			case (i_ds_addr)
				OFS_PA_DATA: pa_data_q <= i_ds_wdata;
				OFS_PB_DATA: pb_data_q <= i_ds_wdata;
				OFS_PA_DIR: pa_dir_q <= i_ds_wdata;
				OFS_PB_DIR: pb_dir_q <= i_ds_wdata;
				OFS_PA_OPT: pa_opt_q <= i_ds_wdata;
				OFS_PB_OPT: pb_opt_q <= i_ds_wdata;
				OFS_CONV_CTL: conv_ctl_q <= i_ds_wdata;
				OFS_TPSC: tpsc_q <= i_ds_wdata;
				OFS_TCNT: tcnt_q <= i_ds_wdata;
				OFS_TSC: tsc_q <= i_ds_wdata;
				OFS_WDG: wdg_q <= i_ds_wdata;
				default: ;
			endcase
		end
	end

	// Direction register steers the pin drivers
	assign o_pa_out = pa_data_q;
	assign o_pa_oe = pa_dir_q;
	assign o_pb_out = pb_data_q;
	assign o_pb_oe = pb_dir_q;

	// Pins: stage three agrees with stage two before a change counts
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
			pin_lvl_q <= '0;
		end else begin
			pin_s1_q <= {i_pb_pin, i_pa_pin};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			for (int p = 0; p < 2; p++) begin
				pin_lvl_q[p] <= (pin_s3_q[p] & ~(pin_s2_q[p] ^ pin_s3_q[p]))
					| (pin_lvl_q[p] & (pin_s2_q[p] ^ pin_s3_q[p]));
			end
		end
	end

	assign pa_view = port_view(pa_data_q, pa_dir_q, pin_lvl_q[0]); // R13
	assign pb_view = port_view(pb_data_q, pb_dir_q, pin_lvl_q[1]); // R13

	// Write-only and reserved locations read as zero
	always_comb begin
		reg_rdata_d = '0;
		case (i_ds_addr)
			OFS_X: reg_rdata_d = x_q;
			OFS_Y: reg_rdata_d = y_q;
			OFS_V: reg_rdata_d = v_q;
			OFS_W_REG: reg_rdata_d = w_q;
			OFS_PA_DATA: reg_rdata_d = pa_view;
			OFS_PB_DATA: reg_rdata_d = pb_view;
			OFS_PA_DIR: reg_rdata_d = pa_dir_q;
			OFS_PB_DIR: reg_rdata_d = pb_dir_q;
			OFS_PA_OPT: reg_rdata_d = pa_opt_q;
			OFS_PB_OPT: reg_rdata_d = pb_opt_q;
			OFS_CONV_RES: reg_rdata_d = i_conv_result;
			OFS_CONV_CTL: reg_rdata_d = conv_ctl_q;
			OFS_TPSC: reg_rdata_d = tpsc_q;
			OFS_TCNT: reg_rdata_d = tcnt_q;
			OFS_TSC: reg_rdata_d = tsc_q;
			OFS_WDG: reg_rdata_d = wdg_q;
			OFS_ACC: reg_rdata_d = acc_q;
			default: reg_rdata_d = '0;
		endcase
	end

	// Two-stage read: memories answer from their own output register
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_q <= 1'b0;
			src_q <= SRC_NONE;
			reg_rdata_q <= '0;
		end else begin
			rd_q <= i_ds_rd;
			src_q <= i_ds_rd ? src_d : SRC_NONE;
			reg_rdata_q <= reg_rdata_d;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ds_rvalid <= 1'b0;
			o_ds_rdata <= '0;
		end else begin
			o_ds_rvalid <= rd_q;
			case (src_q)
				SRC_ROM: o_ds_rdata <= rom_bus.a_data; // R02
				SRC_RAM: o_ds_rdata <= ram_bus.a_data;
				SRC_REG: o_ds_rdata <= reg_rdata_q;
				default: o_ds_rdata <= '0;
			endcase
		end
	end

	// Return stack; overflow drops the deepest entry
	for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_stack
		always_ff @(posedge i_core_clk or posedge i_rst) begin
			if (i_rst) begin
				stk_q[g] <= '0;
			end else if (i_stk_push && i_stk_pop) begin
				if (g == 0) begin
					stk_q[g] <= i_stk_pc;
				end
			end else if (i_stk_push) begin
				stk_q[g] <= (g == 0) ? i_stk_pc : stk_q[(g == 0) ? 0 : g - 1]; // R12
			end else if (i_stk_pop) begin
				stk_q[g] <= (g == STACK_DEPTH - 1) ? '0 : stk_q[(g + 1) % STACK_DEPTH]; // R12
			end
		end
	end

	assign o_stk_top = stk_q[0];

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	sequence win_req_s;
		i_ds_rd && i_ds_addr >= OFS_WIN_LO && i_ds_addr <= OFS_WIN_HI;
	endsequence

	sequence rom_answer_s;
		##1 src_q == SRC_ROM ##1 o_ds_rvalid && o_ds_rdata == $past(rom_bus.a_data);
	endsequence

	win_read_a: assert property (win_req_s |-> rom_answer_s) // R01 R02
		else $error("window read not answered from program memory");

	win_select_a: assert property (i_ds_wr && i_ds_addr == OFS_WIN_SEL |=> // R05 R06 R09
		win_sel_q == $past(i_ds_wdata[SEL_MSB:SEL_LSB]))
		else $error("window select not stored");

	win_addr_a: assert property (win_req_s ##1 1'b1 |-> // R17
		$past(rom_bus.a_addr) == {win_sel_q, $past(i_ds_addr[OFS_W-1:0])}
		|| $past(i_ds_wr))
		else $error("window program address wrong");

	read_latency_a: assert property (i_ds_rd |-> ##1 !o_ds_rvalid || $past(i_ds_rd, 2)
		##1 o_ds_rvalid)
		else $error("read answer not two cycles after request");

	no_spur_a: assert property (!i_ds_rd |-> ##2 !o_ds_rvalid)
		else $error("read valid without request");

	port_read_a: assert property (i_ds_rd && i_ds_addr == OFS_PA_DATA |-> // R13
		##2 o_ds_rdata == $past(pa_view, 2))
		else $error("port read mixes stored and pin bits wrongly");

	wo_read_a: assert property (i_ds_rd
		&& (i_ds_addr == OFS_WIN_SEL || i_ds_addr == OFS_INT_OPT) |->
		##2 o_ds_rvalid && o_ds_rdata == 8'h00)
		else $error("write-only location read nonzero");

	dir_oe_a: assert property (i_ds_wr && i_ds_addr == OFS_PA_DIR |=>
		o_pa_oe == $past(i_ds_wdata))
		else $error("direction write did not steer drive enable");

	stack_push_a: assert property (i_stk_push && !i_stk_pop |=> // R12
		o_stk_top == $past(i_stk_pc) && stk_q[1] == $past(stk_q[0]))
		else $error("push did not stack address");

	stack_pop_a: assert property (i_stk_pop && !i_stk_push |=> // R12
		o_stk_top == $past(stk_q[1]))
		else $error("pop did not expose next entry");
endmodule : dsw_data_space
`default_nettype wire

// [tb/dsw_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
module dsw_core_model (
	input wire logic i_core_clk, // Core clock
	output logic [7:0] o_ds_addr, // Data-space address
	output logic o_ds_rd, // Read strobe
	output logic o_ds_wr, // Write strobe
	output logic [7:0] o_ds_wdata, // Write data
	input wire logic [7:0] i_ds_rdata, // Read data
	input wire logic i_ds_rvalid // Read data valid
);
	logic [7:0] got_q[$];
	int lat_q[$];
	int take_q[$];
	int cyc = 0;
	initial begin
		o_ds_addr = 8'h00;
		o_ds_rd = 1'b0;
		o_ds_wr = 1'b0;
		o_ds_wdata = 8'h00;
	end
	// Whole-byte accesses only; the select register is never read back
	task automatic issue(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge i_core_clk);
		o_ds_rd = !wr;
		o_ds_wr = wr;
		o_ds_addr = a;
		o_ds_wdata = wr ? d : ~o_ds_wdata;
	endtask : issue
	// Released bus shows inverted values so stale data cannot pass
	task automatic idle();
		@(negedge i_core_clk);
		o_ds_rd = 1'b0;
		o_ds_wr = 1'b0;
		o_ds_addr = ~o_ds_addr;
		o_ds_wdata = ~o_ds_wdata;
	endtask : idle
	// Outputs seen here still hold the previous edge's values
	always @(posedge i_core_clk) begin
		cyc = cyc + 1;
		if (o_ds_rd) take_q.push_back(cyc);
		if (i_ds_rvalid) begin
			lat_q.push_back(take_q.size() ? cyc - take_q.pop_front() : -1);
			got_q.push_back(i_ds_rdata);
		end
	end
endmodule : dsw_core_model
`default_nettype wire

// [tb/dsw_data_space_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module dsw_data_space_tb;
	import dsw_pkg::*;
	logic i_core_clk, i_rst, i_ds_rd, i_ds_wr, o_ds_rvalid, i_prog_we, i_stk_push, i_stk_pop;
	logic [7:0] i_ds_addr, i_ds_wdata, o_ds_rdata, o_fetch_data, i_prog_wdata, i_conv_result;
	logic [7:0] pa_pin, pb_pin, o_pa_out, o_pa_oe, o_pb_out, o_pb_oe, da, ra, db, rb, rw_v[9];
	logic [11:0] i_fetch_addr, i_prog_addr, i_stk_pc, o_stk_top, stk[$];
	logic [7:0] mem[4096];
	logic [7:0] exp_q[$];
	logic [5:0] o;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	localparam logic [7:0] RA[9] = '{8'hc4, 8'hc5, 8'hcc, 8'hcd, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd8};
	localparam logic [7:0] RV[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h7f, 8'hff, 8'h00, 8'hfe};
	localparam logic [7:0] WA[9] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff, 8'h84, 8'hbf, 8'hcc, 8'hd1};

	dsw_data_space dsw_data_space_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_ds_addr(i_ds_addr), .i_ds_rd(i_ds_rd), .i_ds_wr(i_ds_wr), .i_ds_wdata(i_ds_wdata),
		.o_ds_rdata(o_ds_rdata), .o_ds_rvalid(o_ds_rvalid), .i_fetch_addr(i_fetch_addr),
		.o_fetch_data(o_fetch_data), .i_prog_we(i_prog_we), .i_prog_addr(i_prog_addr),
		.i_prog_wdata(i_prog_wdata), .i_stk_push(i_stk_push), .i_stk_pop(i_stk_pop),
		.i_stk_pc(i_stk_pc), .o_stk_top(o_stk_top), .i_pa_pin(pa_pin), .o_pa_out(o_pa_out),
		.o_pa_oe(o_pa_oe), .i_pb_pin(pb_pin), .o_pb_out(o_pb_out), .o_pb_oe(o_pb_oe),
		.i_conv_result(i_conv_result));
	dsw_core_model dsw_core_model_i (.i_core_clk(i_core_clk), .o_ds_addr(i_ds_addr),
		.o_ds_rd(i_ds_rd), .o_ds_wr(i_ds_wr), .o_ds_wdata(i_ds_wdata),
		.i_ds_rdata(o_ds_rdata), .i_ds_rvalid(o_ds_rvalid));

	initial begin
		i_core_clk = 1'b0;
		forever #2 i_core_clk = ~i_core_clk;
	end
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	// Whole run needs well under 10k cycles
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chk8
	task automatic chk12(input string what, input logic [11:0] e, input logic [11:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chk12
	function automatic logic [7:0] win_exp(input logic [5:0] b, input logic [5:0] ofs);
		return mem[{b, ofs}];
	endfunction : win_exp
	function automatic logic [7:0] port_exp(input logic [7:0] d, r, p);
		return (d & r) | (p & ~r);
	endfunction : port_exp
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		dsw_core_model_i.issue(1'b0, a, 8'h00);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		dsw_core_model_i.issue(1'b1, a, d);
	endtask : wr
	task automatic flush();
		logic [7:0] g;
		int l;
		dsw_core_model_i.idle();
		repeat (4) @(negedge i_core_clk);
		while (exp_q.size()) begin
			g = 8'hxx;
			l = -1;
			if (dsw_core_model_i.got_q.size()) begin
				g = dsw_core_model_i.got_q.pop_front();
				l = dsw_core_model_i.lat_q.pop_front();
			end
			chk8("read data", exp_q.pop_front(), g);
			chk8("read latency", 8'(RD_LATENCY), 8'(l));
		end
		chk8("extra answers", 8'h00, 8'(dsw_core_model_i.got_q.size()));
	endtask : flush
	task automatic do_reset();
		@(negedge i_core_clk);
		i_rst = 1'b1;
		repeat (2) @(negedge i_core_clk);
		chk8("rdata in reset", 8'h00, o_ds_rdata);
		chk12("stack in reset", 12'h000, o_stk_top);
		i_rst = 1'b0;
	endtask : do_reset

	initial begin
		void'($urandom(32'h5dd87fb0));
		{i_rst, i_prog_we, i_stk_push, i_stk_pop} = 4'b1000;
		{i_fetch_addr, i_prog_addr, i_stk_pc} = '0;
		{i_prog_wdata, i_conv_result, pa_pin, pb_pin} = '0;
		repeat (2) @(negedge i_core_clk);
		i_rst = 1'b0;
		chk8("port a enable", 8'h00, o_pa_oe);
		foreach (RA[k]) rd(RA[k], RV[k]);
		flush();
		foreach (WA[k]) begin
			rw_v[k] = 8'($urandom);
			wr(WA[k], rw_v[k]);
		end
		foreach (WA[k]) rd(WA[k], rw_v[k]);
		wr(8'hc2, 8'hff);
		rd(8'hc2, 8'h00);
		wr(8'hc8, 8'h3c);
		rd(8'hc8, 8'h00);
		rd(8'h00, 8'h00);
		flush();
		for (int a = 0; a < 4096; a++) begin
			@(negedge i_core_clk);
			i_prog_we = 1'b1;
			i_prog_addr = 12'(a);
			i_prog_wdata = 8'($urandom);
			mem[a] = i_prog_wdata;
		end
		@(negedge i_core_clk);
		i_prog_we = 1'b0;
		for (int b = 0; b < 64; b++) begin
			o = 6'($urandom);
			wr(8'hc9, {2'b00, 6'(b)});
			rd(8'h40, win_exp(6'(b), 6'h00));
			rd(8'h7f, win_exp(6'(b), 6'h3f));
			rd({2'b01, o}, win_exp(6'(b), o));
			flush();
		end
		wr(8'h80, 8'h5a);
		rd(8'h3f, 8'h00);
		rd(8'h40, win_exp(6'h3f, 6'h00));
		rd(8'h80, 8'h5a);
		flush();
		for (int k = 0; k < 65; k++) begin
			@(negedge i_core_clk);
			if (k > 0) chk8("fetch", mem[i_fetch_addr], o_fetch_data);
			i_fetch_addr = 12'($urandom);
		end
		for (int k = 0; k < 4; k++) begin
			{da, ra, db, rb} = $urandom;
			{i_conv_result, o} = 14'($urandom);
			wr(8'hc4, ra);
			wr(8'hc0, da);
			wr(8'hc5, rb);
			wr(8'hc1, db);
			{pa_pin, pb_pin} = 16'($urandom);
			repeat (8) @(negedge i_core_clk);
			chk8("port a out", da, o_pa_out);
			chk8("port b enable", rb, o_pb_oe);
			chk8("port b out", db, o_pb_out);
			chk8("port a enable", ra, o_pa_oe);
			rd(8'hc0, port_exp(da, ra, pa_pin));
			rd(8'hc1, port_exp(db, rb, pb_pin));
			rd(8'hd0, i_conv_result);
			flush();
		end
		for (int k = 0; k < 16; k++) begin
			@(negedge i_core_clk);
			if (k > 0) chk12("stack top", stk.size() ? stk[0] : 12'h000, o_stk_top);
			i_stk_push = (k < 8);
			i_stk_pop = (k >= 7 && k < 15);
			i_stk_pc = 12'($urandom);
			if (i_stk_push && i_stk_pop) stk[0] = i_stk_pc;
			else if (i_stk_push) stk.push_front(i_stk_pc);
			else if (i_stk_pop && stk.size()) void'(stk.pop_front());
			if (stk.size() > 6) void'(stk.pop_back());
		end
		wr(8'hc9, 8'h2a);
		flush();
		do_reset();
		rd(8'h45, win_exp(6'h2a, 6'h05));
		flush();
		print_verdict();
	end
endmodule : dsw_data_space_tb
`default_nettype wire
